//--- hw/sam_serial_adc.sv
/*
 * Serial control and data interface of an 8-bit successive-approximation
 * converter with input multiplexer. The host supplies the serial clock as
 * clk_link_i, sampled synchronously; rising and falling edges are detected
 * on the system clock. The analog comparator is outside: this block offers
 * the trial code and reads back one compare bit.
 */
`timescale 1ns/1ps

module sam_serial_adc #(
  parameter int VARIANT = 8,
  parameter int IDLE_HOLD_CYC = sam_pkg::IDLE_HOLD_CYC
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic select_low_n_i,
  input wire logic clk_link_i,
  input wire logic serial_in_i,
  input wire logic lsb_shift_enable_n_i,
  input wire logic compare_i,
  input wire logic pos_below_neg_i,
  output logic serial_out_o,
  output logic serial_out_oe_o,
  output logic conversion_active_o,
  output logic sample_o,
  output logic [7:0] trial_code_o,
  output logic [2:0] pos_chan_o,
  output logic [2:0] neg_chan_o,
  output logic neg_shared_o,
  output logic [7:0] result_o,
  output logic result_valid_o
);

  // ****************************************************************
  // Parameter checks
  // ****************************************************************
  localparam int ADDR_BITS = (VARIANT == sam_pkg::VAR_EIGHT) ? 4 :
                             (VARIANT == sam_pkg::VAR_FOUR) ? 3 : 0;
  localparam int RW = sam_pkg::RESULT_W;
  // Field positions kept in range even when no address word exists
  localparam int ENDED_IDX = (ADDR_BITS == 0) ? 0 : ADDR_BITS - 1;
  localparam int POL_IDX = (ADDR_BITS == 0) ? 0 : ADDR_BITS - 2;

  initial
  begin
    if (VARIANT != sam_pkg::VAR_ONE && VARIANT != sam_pkg::VAR_FOUR
        && VARIANT != sam_pkg::VAR_EIGHT)
      $error("sam_serial_adc: VARIANT must be 1, 4 or 8");
    if (IDLE_HOLD_CYC < 1)
      $error("sam_serial_adc: IDLE_HOLD_CYC must be at least 1");
  end

  // ****************************************************************
  // Link clock edge detection
  // ****************************************************************
  logic link_d_reg;
  logic rise;
  logic fall;

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      link_d_reg <= 1'b0;
    else
      link_d_reg <= clk_link_i;
  end

  assign rise = clk_link_i & ~link_d_reg;
  assign fall = ~clk_link_i & link_d_reg;

  // ****************************************************************
  // Deselect timer
  // ****************************************************************
  logic [15:0] idle_cnt_reg;
  logic idle_clear;

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      idle_cnt_reg <= 16'h0000;
    else if (!select_low_n_i)
      idle_cnt_reg <= 16'h0000;
    else if (idle_cnt_reg < 16'(IDLE_HOLD_CYC))
      idle_cnt_reg <= idle_cnt_reg + 16'h0001;
  end

  // Active state is also dropped at once on deselect, so a short glitch
  // high aborts the transfer; the timer only gates the fresh start.
  assign idle_clear = select_low_n_i && (idle_cnt_reg >= 16'(IDLE_HOLD_CYC));

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  sam_pkg::sam_state_t state_reg;
  logic [3:0] addr_sr_reg;
  logic [2:0] addr_cnt_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] sar_reg;
  logic [7:0] shift_reg;
  logic armed_reg;
  logic ended_reg;
  logic polarity_reg;
  logic [1:0] select_reg;
  logic active_reg;
  logic out_reg;
  logic oe_reg;
  logic [7:0] sar_next;

  // Next trial: current bit decided by compare, next lower bit set
  always_comb
  begin
    sar_next = sar_reg;
    sar_next[RW - 1 - bit_cnt_reg[2:0]] = compare_i & ~pos_below_neg_i;
    if (bit_cnt_reg < 4'(RW - 1))
      sar_next[RW - 2 - bit_cnt_reg[2:0]] = 1'b1;
  end

  // A fresh conversion is allowed only after reset or once the idle time was met
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      armed_reg <= 1'b1;
    else if (idle_clear)
      armed_reg <= 1'b1;
    else if (state_reg == sam_pkg::SAM_SAMPLE)
      armed_reg <= 1'b0;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i || select_low_n_i)
    begin
      state_reg <= sam_pkg::SAM_IDLE;
      addr_sr_reg <= 4'h0;
      addr_cnt_reg <= 3'h0;
      bit_cnt_reg <= 4'h0;
      sar_reg <= sam_pkg::RESULT_RST;
      shift_reg <= sam_pkg::RESULT_RST;
      active_reg <= 1'b0;
      out_reg <= 1'b0;
      oe_reg <= 1'b0;
    end
    else
    begin
      case (state_reg)
        sam_pkg::SAM_IDLE:
        begin
          if (armed_reg)
            state_reg <= sam_pkg::SAM_ADDR;
        end
        sam_pkg::SAM_ADDR:
        begin
          if (rise)
          begin
            if (addr_cnt_reg == 3'h0)
            begin
              if (serial_in_i)
              begin
                addr_cnt_reg <= 3'h1;
                if (ADDR_BITS == 0)
                  state_reg <= sam_pkg::SAM_SAMPLE;
              end
            end
            else
            begin
              addr_sr_reg <= {addr_sr_reg[2:0], serial_in_i};
              addr_cnt_reg <= addr_cnt_reg + 3'h1;
              if (addr_cnt_reg == 3'(ADDR_BITS))
                state_reg <= sam_pkg::SAM_SAMPLE;
            end
          end
        end
        sam_pkg::SAM_SAMPLE:
        begin
          // Half period: the falling edge after the last address bit
          if (fall)
          begin
            state_reg <= sam_pkg::SAM_CONV;
            active_reg <= 1'b1;
            oe_reg <= 1'b1;
            out_reg <= 1'b0;
            sar_reg <= 8'h80;
            bit_cnt_reg <= 4'h0;
          end
        end
        sam_pkg::SAM_CONV:
        begin
          if (fall)
          begin
            sar_reg <= sar_next;
            out_reg <= sar_next[RW - 1 - bit_cnt_reg[2:0]];
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            if (bit_cnt_reg == 4'(RW - 1))
            begin
              // Copy shifted down one so bit 1 leaves next; the LSB has just gone out
              shift_reg <= {1'b0, sar_next[7:1]};
              if (VARIANT == sam_pkg::VAR_ONE)
                state_reg <= sam_pkg::SAM_DONE;
              else
                state_reg <= sam_pkg::SAM_LSB;
              bit_cnt_reg <= 4'h0;
            end
          end
          if (rise && bit_cnt_reg == 4'(RW))
            active_reg <= 1'b0;
        end
        sam_pkg::SAM_LSB:
        begin
          // Conversion ended on the last falling edge; active falls next rise
          if (rise && active_reg)
            active_reg <= 1'b0;
          if (fall && (VARIANT != sam_pkg::VAR_EIGHT || !lsb_shift_enable_n_i))
          begin
            out_reg <= shift_reg[0];
            shift_reg <= {1'b0, shift_reg[7:1]};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            if (bit_cnt_reg == 4'(RW - 2))
              state_reg <= sam_pkg::SAM_DONE;
          end
        end
        sam_pkg::SAM_DONE:
        begin
          if (rise && active_reg)
            active_reg <= 1'b0;
          if (fall && !active_reg)
            out_reg <= 1'b0;
        end
        default:
          state_reg <= sam_pkg::SAM_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Per-conversion configuration and result
  // ****************************************************************
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      ended_reg <= 1'b0;
      polarity_reg <= 1'b0;
      select_reg <= 2'b00;
    end
    else if (state_reg == sam_pkg::SAM_SAMPLE && fall)
    begin
      // Latched once per transaction and held, through deselect, until the next sample phase ends
      ended_reg <= (ADDR_BITS == 0) ? 1'b0 : addr_sr_reg[ENDED_IDX];
      polarity_reg <= (ADDR_BITS == 0) ? 1'b0 : addr_sr_reg[POL_IDX];
      select_reg <= (ADDR_BITS == 4) ? addr_sr_reg[1:0] : {1'b0, addr_sr_reg[0]};
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i || select_low_n_i)
    begin
      result_o <= sam_pkg::RESULT_RST;
      result_valid_o <= 1'b0;
    end
    else if (state_reg == sam_pkg::SAM_CONV && fall && bit_cnt_reg == 4'(RW - 1))
    begin
      result_o <= sar_next;
      result_valid_o <= 1'b1;
    end
  end

  sam_mux_decode #(
    .VARIANT(VARIANT)
  ) u_decode (
    .ended_vs_pair_i(ended_reg),
    .pair_polarity_i(polarity_reg),
    .select_i(select_reg),
    .pos_chan_o(pos_chan_o),
    .neg_chan_o(neg_chan_o),
    .neg_shared_o(neg_shared_o)
  );

  assign serial_out_o = out_reg;
  assign serial_out_oe_o = oe_reg;
  assign conversion_active_o = active_reg;
  assign sample_o = (state_reg == sam_pkg::SAM_SAMPLE);
  assign trial_code_o = sar_reg;

endmodule : sam_serial_adc

//--- hw/sam_pkg.sv
/*
 * Constants shared by the serial converter interface: variant codes,
 * result width, mux assignment field layout and timing counts.
 * Assumes a single 100 MHz system clock and synchronous active-low reset.
 */
package sam_pkg;

  // ****************************************************************
  // Variants and widths
  // ****************************************************************
  localparam int VAR_ONE = 1;
  localparam int VAR_FOUR = 4;
  localparam int VAR_EIGHT = 8;
  localparam int RESULT_W = 8;
  localparam int CHAN_W = 3;

  // ****************************************************************
  // Mux assignment word layout, in arrival order after the start bit
  // ****************************************************************
  localparam int FLD_ENDED_POS = 0;
  localparam int FLD_POLARITY_POS = 1;
  localparam int FLD_SELECT_POS = 2;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 10;
  // Deselect time before a fresh conversion is armed again
  localparam int IDLE_HOLD_NS = 250;
  localparam int IDLE_HOLD_CYC = (IDLE_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] RESULT_RST = 8'h00;
  localparam logic [2:0] CHAN_RST = 3'h0;

  typedef enum logic [2:0] {
    SAM_IDLE,
    SAM_ADDR,
    SAM_SAMPLE,
    SAM_CONV,
    SAM_LSB,
    SAM_DONE
  } sam_state_t;

endpackage : sam_pkg

//--- hw/sam_mux_decode.sv
/*
 * Combinational decode of the mux assignment word into the positive and
 * negative input selections. Assumes the word was captured complete.
 */
`timescale 1ns/1ps
module sam_mux_decode #(
  parameter int VARIANT = 8
) (
  input wire logic ended_vs_pair_i,
  input wire logic pair_polarity_i,
  input wire logic [1:0] select_i,
  output logic [2:0] pos_chan_o,
  output logic [2:0] neg_chan_o,
  output logic neg_shared_o
);

  initial
  begin
    if (VARIANT != sam_pkg::VAR_ONE && VARIANT != sam_pkg::VAR_FOUR
        && VARIANT != sam_pkg::VAR_EIGHT)
      $error("sam_mux_decode: VARIANT must be 1, 4 or 8");
  end

  logic [2:0] pair_base;

  always_comb
  begin
    pair_base = sam_pkg::CHAN_RST;
    pos_chan_o = sam_pkg::CHAN_RST;
    neg_chan_o = 3'h1;
    neg_shared_o = 1'b0;
    if (VARIANT == sam_pkg::VAR_EIGHT)
      pair_base = {select_i, 1'b0};
    else if (VARIANT == sam_pkg::VAR_FOUR)
      pair_base = {1'b0, select_i[0], 1'b0};
    if (VARIANT == sam_pkg::VAR_ONE)
    begin
      // Fixed pair, fixed polarity
      pos_chan_o = 3'h0;
      neg_chan_o = 3'h1;
    end
    else if (ended_vs_pair_i)
    begin
      // Twice the select plus polarity; negative is the shared return
      pos_chan_o = pair_base | {2'b00, pair_polarity_i};
      neg_shared_o = 1'b1;
    end
    else
    begin
      pos_chan_o = pair_base | {2'b00, pair_polarity_i};
      neg_chan_o = pair_base | {2'b00, ~pair_polarity_i};
    end
  end

endmodule : sam_mux_decode

//--- test/sam_serial_chk.sv
/* Port checker for the serial converter interface.
   Assumes one system clock and a synchronous active-low reset. */
`timescale 1ns/1ps
module sam_serial_chk (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic select_low_n_i,
  input wire logic pos_below_neg_i,
  input wire logic serial_out_o,
  input wire logic serial_out_oe_o,
  input wire logic conversion_active_o,
  input wire logic sample_o,
  input wire logic [7:0] trial_code_o,
  input wire logic [2:0] pos_chan_o,
  input wire logic [7:0] result_o,
  input wire logic result_valid_o
);
  default clocking @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);
  // ****
  // Assertions
  // ****
  deselect_quiet_a: assert property (select_low_n_i [*2] |-> !serial_out_oe_o)
    else $error("serial_out driven while deselected");
  lead_zero_a: assert property ($rose(serial_out_oe_o) |-> !serial_out_o)
    else $error("first driven bit is not zero");
  active_drive_a: assert property (conversion_active_o |-> serial_out_oe_o)
    else $error("converting with serial_out undriven");
  sample_first_a: assert property ($rose(conversion_active_o) |-> $past(sample_o))
    else $error("conversion began without sampling");
  first_trial_a: assert property ($rose(conversion_active_o) |-> trial_code_o == 8'h80)
    else $error("first trial code is not midscale");
  chan_held_a: assert property (conversion_active_o && $past(conversion_active_o)
    |-> $stable(pos_chan_o))
    else $error("channel moved during conversion");
  end_valid_a: assert property (!select_low_n_i && $fell(conversion_active_o) |-> result_valid_o)
    else $error("conversion ended without result");
  below_zero_a: assert property ($rose(result_valid_o) && pos_below_neg_i |-> result_o == 8'h00)
    else $error("reversed input gave nonzero code");
  valid_drive_a: assert property (result_valid_o |-> serial_out_oe_o)
    else $error("serial_out released before deselect");
  conv_c: cover property ($rose(result_valid_o));
  end_c: cover property ($fell(conversion_active_o) && !select_low_n_i);
  below_c: cover property (pos_below_neg_i && result_valid_o);
endmodule : sam_serial_chk

//--- test/sam_host.sv
/* Host model: drives select, link clock and serial input, reads serial_out.
   Assumes tasks are called just after a rising system clock edge. */
`timescale 1ns/1ps
module sam_host #(
  parameter int HALF = 4
) (
  input wire logic clk_sys_i,
  input wire logic serial_out_i,
  output logic select_low_n_o,
  output logic clk_link_o,
  output logic serial_in_o,
  output logic lsb_shift_enable_n_o
);
  initial
  begin
    select_low_n_o = 1'b1;
    clk_link_o = 1'b0;
    serial_in_o = 1'b0;
    lsb_shift_enable_n_o = 1'b0;
  end
  // Link clock only runs inside frames; data read just before each rise
  task automatic link_bit(input logic din, output logic seen);
    serial_in_o <= din;
    repeat (HALF) @(posedge clk_sys_i);
    seen = serial_out_i;
    clk_link_o <= 1'b1;
    repeat (HALF) @(posedge clk_sys_i);
    clk_link_o <= 1'b0;
  endtask : link_bit
  task automatic run_frame(input logic [3:0] word, input int zeros, input int n_out,
    input logic se_n, output logic [17:0] bits);
    logic seen;
    bits = '0;
    lsb_shift_enable_n_o <= se_n;
    select_low_n_o <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    for (int k = 0; k < zeros; k++) link_bit(1'b0, seen);
    link_bit(1'b1, seen);
    for (int k = 3; k >= 0; k--) link_bit(word[k], seen);
    // Released data line toggles so a stale level is never mistaken for data
    for (int k = 0; k < n_out; k++)
    begin
      link_bit(~serial_in_o, seen);
      bits[k] = seen;
    end
  endtask : run_frame
  task automatic deselect(input int cycles);
    select_low_n_o <= 1'b1;
    serial_in_o <= ~serial_in_o;
    repeat (cycles) @(posedge clk_sys_i);
  endtask : deselect
endmodule : sam_host

//--- test/sam_serial_adc_bench.sv
/* Bench for the eight-input converter interface with a comparator model.
   Assumes the host model and checker files are compiled first. */
`timescale 1ns/1ps
module sam_serial_adc_bench;
  localparam int IDLE_CYC = 2;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic compare_i = 1'b0;
  logic pos_below_neg_i = 1'b0;
  logic [7:0] level = 8'h00;
  logic select_low_n, clk_link, serial_in, se_n_pin, serial_out, serial_out_oe;
  logic conversion_active, neg_shared, result_valid;
  logic [7:0] trial_code, result;
  logic [2:0] pos_chan, neg_chan;
  int n_mismatch = 0;
  int cmp_count = 0;
  always #5 clk_sys_i = ~clk_sys_i;
  // Comparator: input at or above trial keeps the bit, so the code settles on level
  always @(posedge clk_sys_i) compare_i <= (level >= trial_code);
  sam_serial_adc #(.VARIANT(8), .IDLE_HOLD_CYC(IDLE_CYC)) sam_serial_adc_inst (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .select_low_n_i(select_low_n),
    .clk_link_i(clk_link), .serial_in_i(serial_in), .lsb_shift_enable_n_i(se_n_pin),
    .compare_i(compare_i), .pos_below_neg_i(pos_below_neg_i), .serial_out_o(serial_out),
    .serial_out_oe_o(serial_out_oe), .conversion_active_o(conversion_active), .sample_o(),
    .trial_code_o(trial_code), .pos_chan_o(pos_chan), .neg_chan_o(neg_chan),
    .neg_shared_o(neg_shared), .result_o(result), .result_valid_o(result_valid));
  sam_host sam_host_inst (.clk_sys_i(clk_sys_i), .serial_out_i(serial_out),
    .select_low_n_o(select_low_n), .clk_link_o(clk_link), .serial_in_o(serial_in),
    .lsb_shift_enable_n_o(se_n_pin));
  task automatic check_stream(input string what, input logic [17:0] exp, input logic [17:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check_stream
  task automatic check_val(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check_val
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : wrap_up
  initial
  begin : main
    logic [3:0] word;
    logic [7:0] code;
    logic [17:0] bits, exp;
    logic se_n;
    repeat (4) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    repeat (IDLE_CYC + 2) @(posedge clk_sys_i);
    // Every mode, polarity and select code; midway one frame is cut short
    for (int i = 0; i < 16; i++)
    begin
      word = i[3:0];
      se_n = (i == 5);
      code = (i == 9) ? 8'h00 : 8'(i * 17);
      level <= 8'(i * 17);
      pos_below_neg_i <= (i == 9);
      if (i == 12)
      begin
        sam_host_inst.run_frame(4'h5, 0, 6, 1'b0, bits);
        sam_host_inst.deselect(IDLE_CYC + 4);
      end
      sam_host_inst.run_frame(word, i % 3, 18, se_n, bits);
      exp = '0;
      for (int k = 1; k <= 8; k++) exp[k] = code[8 - k];
      for (int k = 9; k <= 17; k++) exp[k] = se_n ? code[0] : (k < 16 ? code[k - 8] : 1'b0);
      check_stream("serial_out stream", exp, bits);
      check_val("result", code, result);
      check_val("positive channel", {5'h00, word[1:0], word[2]}, {5'h00, pos_chan});
      check_val("shared negative", {7'h00, word[3]}, {7'h00, neg_shared});
      if (!word[3])
        check_val("negative channel", {5'h00, word[1:0], ~word[2]}, {5'h00, neg_chan});
      check_val("valid and active", 8'h02, {6'h00, result_valid, conversion_active});
      sam_host_inst.deselect(IDLE_CYC + 4);
      check_val("after deselect", 8'h00, {6'h00, serial_out_oe, result_valid});
    end
    wrap_up();
  end
  initial
  begin
    repeat (20000) @(posedge clk_sys_i);
    n_mismatch++;
    wrap_up();
  end
endmodule : sam_serial_adc_bench
bind sam_serial_adc sam_serial_chk sam_serial_chk_inst (.clk_sys_i(clk_sys_i),
  .rst_n_i(rst_n_i), .select_low_n_i(select_low_n_i), .pos_below_neg_i(pos_below_neg_i),
  .serial_out_o(serial_out_o), .serial_out_oe_o(serial_out_oe_o),
  .conversion_active_o(conversion_active_o), .sample_o(sample_o),
  .trial_code_o(trial_code_o), .pos_chan_o(pos_chan_o), .result_o(result_o),
  .result_valid_o(result_valid_o));
